// File: logic/vlts_line_map.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// line counter to selector entry
// ----------------------------------------------------------------------
module vlts_line_map
    import vlts_pkg::*;
(
    input  wire logic [9:0] i_line_cnt,
    input  wire logic [8:0] i_vertical_line_offset,
    input  wire logic       i_field_offset_flag,
    input  wire logic       i_field2,
    output logic      [4:0] o_sel_idx
);
    logic [11:0] line_num;
    logic        adj;

    // field two without offset flag sits one line later
    always_comb begin
        adj      = i_field2 & ~i_field_offset_flag;
        line_num = {2'b00, i_line_cnt} + MAP_PIVOT - {3'b000, i_vertical_line_offset} - {11'h000, adj};
        if (!line_num[11] && line_num >= {7'h00, SEL_FIRST_LINE}
            && line_num <= {7'h00, SEL_LAST_LINE}) begin
            o_sel_idx = line_num[4:0] - SEL_FIRST_LINE;
        end else begin
            o_sel_idx = SEL_REST_IDX;
        end
    end
endmodule
`default_nettype wire

// File: logic/vlts_pkg.sv
package vlts_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_SEL_FIRST  = 8'h41;   // selector for line 2
    localparam logic [7:0]  IDX_SEL_LAST   = 8'h57;   // selector 24, rest of field
    localparam logic [7:0]  IDX_HORIZONTAL_PIXEL_OFFSET_LO    = 8'h59;
    localparam logic [7:0]  IDX_VERTICAL_LINE_OFFSET_LO    = 8'h5a;
    localparam logic [7:0]  IDX_OFFS_HI    = 8'h5b;
    localparam logic [7:0]  IDX_ROUTE      = 8'h5c;
    localparam logic [7:0]  IDX_STATUS     = 8'h5d;
    localparam int          ADDR_W         = 12;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          OFFS_FIELD_OFFSET_FLAG_BIT  = 7;       // field offset flag
    localparam int          OFFS_VOFF8_BIT = 4;       // vertical offset msb
    localparam int          OFFS_HORIZONTAL_PIXEL_OFFSET_MSB  = 2;       // horizontal offset upper bits
    localparam int          ROUTE_RT0_LSB  = 0;
    localparam int          ROUTE_RT1_LSB  = 4;
    localparam int          ROUTE_XRH_BIT  = 8;
    localparam int          ROUTE_XRV_LSB  = 12;
    localparam int          STAT_SEL_LSB   = 10;
    localparam int          STAT_CODE_LSB  = 16;
    localparam int          STAT_FIELD_BIT = 24;

    // ------------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------------
    localparam int          NUM_SEL        = 23;      // selectors 2..24
    localparam logic [4:0]  SEL_FIRST_LINE = 5'h02;
    localparam logic [4:0]  SEL_LAST_LINE  = 5'h17;   // selector 23
    localparam logic [4:0]  SEL_REST_IDX   = 5'h16;   // entry of selector 24
    localparam logic [11:0] MAP_PIVOT      = 12'h003; // counter to selector shift
    localparam logic [7:0]  RST_SEL        = 8'hff;
    localparam logic [8:0]  RST_VERTICAL_LINE_OFFSET       = 9'h003;
    localparam logic [10:0] RST_HORIZONTAL_PIXEL_OFFSET       = 11'h347;
    localparam logic        RST_FIELD_OFFSET_FLAG       = 1'b0;
    localparam logic [9:0]  LINE_CNT_MAX   = 10'h3ff;

    // ------------------------------------------------------------------
    // data type codes
    // ------------------------------------------------------------------
    localparam logic [3:0]  CODE_VBI_COMP  = 4'h6;
    localparam logic [3:0]  CODE_ACT_COMP  = 4'hf;

    // ------------------------------------------------------------------
    // routing choices
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RT_LOW   = 3'b000,
        RT_HORIZONTAL_REFERENCE  = 3'b001,
        RT_VPULS = 3'b010,
        RT_VERTICAL_GATE = 3'b011,
        RT_FIELD = 3'b100
    } vlts_rt_e;

    typedef enum logic [1:0] {
        XRV_LOW   = 2'b00,
        XRV_F656  = 2'b01,
        XRV_VPULS = 2'b10
    } vlts_xrv_e;

    // reference signals from sync generation
    typedef struct packed {
        logic horizontal_reference;
        logic field_flag_656;
        logic vertical_pulse;
        logic vertical_gate;
        logic field_identifier;
    } vlts_ref_s;

    // pixel stream with its data type marks
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic        set_raw;
        logic        set_vbi;
    } vlts_pix_s;

endpackage

// File: logic/vlts_top.sv
`timescale 1ns/1ps
`default_nettype none
module vlts_top
    import vlts_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst_n,
    // apb slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // line and field timing
    input  wire logic              i_line_start,
    input  wire logic              i_field_start,
    input  wire logic              i_field2,
    input  wire vlts_ref_s         i_ref,
    // sample stream
    input  wire logic              i_pix_valid,
    input  wire logic [15:0]       i_pix_data,
    output vlts_pix_s              o_pix,
    output logic                   o_set_active,
    // reference pins
    output logic                   o_realtime_out_0,
    output logic                   o_realtime_out_1,
    output logic                   o_expansion_horiz_ref_pin,
    output logic                   o_expansion_vert_ref_pin
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_SEL-1:0][7:0] sel;
        logic [8:0]              vertical_line_offset;
        logic [10:0]             horizontal_pixel_offset;
        logic                    field_offset_flag;
        vlts_rt_e                rt0_sel;
        vlts_rt_e                rt1_sel;
        logic                    xrh_en;
        vlts_xrv_e               xrv_sel;
        logic [9:0]              line_cnt;
        logic                    field2;
        logic [4:0]              sel_idx;
        logic [3:0]              code;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
        vlts_pix_s               pix;
        logic                    set_active;
        logic                    rt0;
        logic                    rt1;
        logic                    expansion_horiz_ref_pin;
        logic                    expansion_vert_ref_pin;
    } vlts_state_s;

    vlts_state_s st;
    vlts_state_s next_st;

    logic [4:0]  map_idx;
    logic        dec_raw;
    logic        dec_vbi;
    logic        dec_act;
    logic [3:0]  map_code;
    logic [7:0]  widx;
    logic        setup;
    logic        access;
    logic [7:0]  map_entry;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [9:0]  next_line_cnt;
    logic        next_field2;

    // ------------------------------------------------------------------
    // leaf logic
    // ------------------------------------------------------------------
    // the map looks at the line that starts now, so it is fed the
    // coming counter and field rather than the registered ones
    vlts_line_map u_map (
        .i_line_cnt (next_line_cnt),
        .i_vertical_line_offset     (st.vertical_line_offset),
        .i_field_offset_flag     (st.field_offset_flag),
        .i_field2   (next_field2),
        .o_sel_idx  (map_idx)
    );

    vlts_type_decode u_dec (
        .i_code       (map_code),
        .o_set_raw    (dec_raw),
        .o_set_vbi    (dec_vbi),
        .o_set_active (dec_act)
    );

    // counter and field of the coming cycle, apart from the state copy
    // so that the selector lookup reads no output of its own process;
    // a field start wins over a line start in the same cycle
    always_comb begin
        next_line_cnt = st.line_cnt;
        next_field2   = st.field2;
        if (i_field_start) begin
            next_line_cnt = 10'h000;                          // field start is line 0
            next_field2   = i_field2;
        end else if (i_line_start && st.line_cnt != LINE_CNT_MAX) begin
            next_line_cnt = st.line_cnt + 10'h001;            // saturates at the top
        end
    end

    // field one code in upper nibble, field two in lower
    always_comb begin
        map_entry = st.sel[map_idx];
        map_code  = next_field2 ? map_entry[3:0] : map_entry[7:4];
    end

    // ------------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------------
    // misaligned or out of range addresses clear the hit flag, which
    // turns into the error answer and blocks any write
    always_comb begin
        widx    = i_paddr[9:2];
        setup   = i_psel & ~i_penable;
        access  = i_psel & i_penable & st.pready;
        rd_word = 32'h0000_0000;
        rd_hit  = (i_paddr[1:0] == 2'b00) && (i_paddr[ADDR_W-1:10] == 2'b00);
        if (widx >= IDX_SEL_FIRST && widx <= IDX_SEL_LAST) begin
            rd_word[7:0] = st.sel[widx - IDX_SEL_FIRST];
        end else begin
            unique case (widx)
                IDX_HORIZONTAL_PIXEL_OFFSET_LO: rd_word[7:0] = st.horizontal_pixel_offset[7:0];
                IDX_VERTICAL_LINE_OFFSET_LO: rd_word[7:0] = st.vertical_line_offset[7:0];
                IDX_OFFS_HI: begin
                    rd_word[OFFS_FIELD_OFFSET_FLAG_BIT]           = st.field_offset_flag;
                    rd_word[OFFS_VOFF8_BIT]          = st.vertical_line_offset[8];
                    rd_word[OFFS_HORIZONTAL_PIXEL_OFFSET_MSB:0]         = st.horizontal_pixel_offset[10:8];
                end
                IDX_ROUTE: begin
                    rd_word[ROUTE_RT0_LSB+:3]        = st.rt0_sel;
                    rd_word[ROUTE_RT1_LSB+:3]        = st.rt1_sel;
                    rd_word[ROUTE_XRH_BIT]           = st.xrh_en;
                    rd_word[ROUTE_XRV_LSB+:2]        = st.xrv_sel;
                end
                IDX_STATUS: begin
                    rd_word[9:0]                     = st.line_cnt;
                    rd_word[STAT_SEL_LSB+:5]         = st.sel_idx;
                    rd_word[STAT_CODE_LSB+:4]        = st.code;
                    rd_word[STAT_FIELD_BIT]          = st.field2;
                end
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // apb: answer prepared in setup, given in first access cycle
        // zero wait states; ready and error stand for one cycle and fall
        // at the completing edge, read data holds to the next setup; back to back is fine
        if (setup) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = ~rd_hit;
            next_st.prdata  = (rd_hit && !i_pwrite) ? rd_word : 32'h0000_0000;
        end else if (access) begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
        end

        // register writes take effect at the completing edge
        if (access && i_pwrite && rd_hit) begin
            if (widx >= IDX_SEL_FIRST && widx <= IDX_SEL_LAST) begin
                next_st.sel[widx - IDX_SEL_FIRST] = i_pwdata[7:0];
            end else begin
                unique case (widx)
                    IDX_HORIZONTAL_PIXEL_OFFSET_LO: next_st.horizontal_pixel_offset[7:0] = i_pwdata[7:0];
                    IDX_VERTICAL_LINE_OFFSET_LO: next_st.vertical_line_offset[7:0] = i_pwdata[7:0];
                    IDX_OFFS_HI: begin
                        next_st.field_offset_flag       = i_pwdata[OFFS_FIELD_OFFSET_FLAG_BIT];
                        next_st.vertical_line_offset[8]    = i_pwdata[OFFS_VOFF8_BIT];
                        next_st.horizontal_pixel_offset[10:8] = i_pwdata[OFFS_HORIZONTAL_PIXEL_OFFSET_MSB:0];
                    end
                    IDX_ROUTE: begin
                        next_st.rt0_sel = vlts_rt_e'(i_pwdata[ROUTE_RT0_LSB+:3]);
                        next_st.rt1_sel = vlts_rt_e'(i_pwdata[ROUTE_RT1_LSB+:3]);
                        next_st.xrh_en  = i_pwdata[ROUTE_XRH_BIT];
                        next_st.xrv_sel = vlts_xrv_e'(i_pwdata[ROUTE_XRV_LSB+:2]);
                    end
                    default: ;
                endcase
            end
        end

        // line counting within the field, worked out above
        next_st.line_cnt = next_line_cnt;
        next_st.field2   = next_field2;

        // code of the current line, fixed at each line start
        if (i_field_start || i_line_start) begin
            next_st.sel_idx = map_idx;
            next_st.code    = map_code;
        end

        // samples carry the type of the line they belong to
        next_st.pix.valid  = i_pix_valid;
        next_st.pix.data   = i_pix_data;
        if (i_field_start || i_line_start) begin
            next_st.pix.set_raw = dec_raw;
            next_st.pix.set_vbi = dec_vbi;
            next_st.set_active  = dec_act;
        end

        // reference pin routing, forbidden pairings not encodable
        // unused select codes read back as written but drive the pin low,
        // so a stray write can never put a wrong reference on a pin
        unique case (st.rt0_sel)
            RT_HORIZONTAL_REFERENCE:  next_st.rt0 = i_ref.horizontal_reference;
            RT_VPULS: next_st.rt0 = i_ref.vertical_pulse;
            RT_VERTICAL_GATE: next_st.rt0 = i_ref.vertical_gate;
            RT_FIELD: next_st.rt0 = i_ref.field_identifier;
            default:  next_st.rt0 = 1'b0;
        endcase
        unique case (st.rt1_sel)
            RT_HORIZONTAL_REFERENCE:  next_st.rt1 = i_ref.horizontal_reference;
            RT_VPULS: next_st.rt1 = i_ref.vertical_pulse;
            RT_VERTICAL_GATE: next_st.rt1 = i_ref.vertical_gate;
            RT_FIELD: next_st.rt1 = i_ref.field_identifier;
            default:  next_st.rt1 = 1'b0;
        endcase
        next_st.expansion_horiz_ref_pin = st.xrh_en & i_ref.horizontal_reference;
        unique case (st.xrv_sel)
            XRV_F656:  next_st.expansion_vert_ref_pin = i_ref.field_flag_656;
            XRV_VPULS: next_st.expansion_vert_ref_pin = i_ref.vertical_pulse;
            default:   next_st.expansion_vert_ref_pin = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // selectors come up as active video everywhere, and the marks
    // agree with that code until the first line start
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st            <= '0;
            st.sel        <= {NUM_SEL{RST_SEL}};
            st.vertical_line_offset       <= RST_VERTICAL_LINE_OFFSET;
            st.horizontal_pixel_offset       <= RST_HORIZONTAL_PIXEL_OFFSET;
            st.field_offset_flag       <= RST_FIELD_OFFSET_FLAG;
            st.rt0_sel    <= RT_LOW;
            st.rt1_sel    <= RT_LOW;
            st.xrv_sel    <= XRV_LOW;
            st.sel_idx    <= SEL_REST_IDX;
            st.code       <= CODE_ACT_COMP;
            st.pix.set_raw <= 1'b0;
            st.pix.set_vbi <= 1'b0;
            st.set_active <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign o_prdata                  = st.prdata;
    assign o_pready                  = st.pready;
    assign o_pslverr                 = st.pslverr;
    assign o_pix                     = st.pix;
    assign o_set_active              = st.set_active;
    assign o_realtime_out_0          = st.rt0;
    assign o_realtime_out_1          = st.rt1;
    assign o_expansion_horiz_ref_pin = st.expansion_horiz_ref_pin;
    assign o_expansion_vert_ref_pin  = st.expansion_vert_ref_pin;
endmodule
`default_nettype wire

// File: logic/vlts_type_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// data type code to path controls
// ----------------------------------------------------------------------
module vlts_type_decode
    import vlts_pkg::*;
(
    input  wire logic [3:0] i_code,
    output logic            o_set_raw,
    output logic            o_set_vbi,
    output logic            o_set_active
);
    // only codes 6 and 15 give component video
    always_comb begin
        o_set_vbi    = (i_code == CODE_VBI_COMP);
        o_set_active = (i_code == CODE_ACT_COMP);
        o_set_raw    = ~o_set_vbi & ~o_set_active;
    end
endmodule
`default_nettype wire

// File: verif/vlts_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// register, line mapping and routing tests
// ----------------------------------------------------------------------
module vlts_bench
    import vlts_pkg::*;
;
    logic              clk, rst_n, psel, pen, pwr, pready, perr, ev;
    logic              gol, gof, f2, ls, fs, sf2, pv, act, rt0, rt1, expansion_horiz_ref_pin, expansion_vert_ref_pin;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rdv;
    logic [15:0]       pd, dsave;
    vlts_ref_s         rf;
    vlts_pix_s         pix;
    logic [7:0]        sel_v [2:24];
    int                error_cnt, n_checks;

    vlts_line_src src_u (.i_mclk(clk), .i_rst_n(rst_n), .i_go_line(gol), .i_go_field(gof),
        .i_f2(f2), .o_line_start(ls), .o_field_start(fs), .o_field2(sf2),
        .o_pix_valid(pv), .o_pix_data(pd));
    vlts_top dut_u (.i_mclk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .i_line_start(ls), .i_field_start(fs),
        .i_field2(sf2), .i_ref(rf), .i_pix_valid(pv), .i_pix_data(pd), .o_pix(pix),
        .o_set_active(act), .o_realtime_out_0(rt0), .o_realtime_out_1(rt1),
        .o_expansion_horiz_ref_pin(expansion_horiz_ref_pin), .o_expansion_vert_ref_pin(expansion_vert_ref_pin));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one bus transfer, waits for ready under a bound
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) chk(32'h0, 32'h1);
        rdv = prdata;
        ev  = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic e);
        apb(1'b0, idx, 32'h0);
        chk(rdv, exp);
        chk({31'h0, ev}, {31'h0, e});
    endtask

    // one field or line start, then marks and status compared
    task automatic line(input logic fld, input logic [9:0] cnt, input logic [8:0] vo,
                        input logic fo);
        int         n;
        logic [4:0] ent;
        logic [3:0] code;
        @(posedge clk);
        gof <= fld;
        gol <= !fld;
        @(posedge clk);
        gof <= 1'b0;
        gol <= 1'b0;
        #1 dsave = pd;
        @(posedge clk);
        #1;
        n    = int'(cnt) + 3 - int'(vo) - int'(f2 & !fo);
        ent  = (n >= 2 && n <= 23) ? 5'(n) : 5'd24;
        code = f2 ? sel_v[ent][3:0] : sel_v[ent][7:4];
        chk({15'h0, pix.valid, pix.data}, {15'h0, 1'b1, dsave});
        chk({29'h0, pix.set_raw, pix.set_vbi, act},
            {29'h0, code != 4'h6 && code != 4'hf, code == 4'h6, code == 4'hf});
        rd(IDX_STATUS, {7'h0, f2, 4'h0, code, 1'b0, ent - 5'd2, cnt}, 1'b0);
    endtask

    task automatic walk(input logic fv, input logic [8:0] vo, input logic fo, input int last);
        f2 <= fv;
        for (int c = 0; c <= last; c++) line(c == 0, 10'(c), vo, fo);
    endtask

    initial begin
        rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        gol = 1'b0; gof = 1'b0; f2 = 1'b0; rf = 5'h0; error_cnt = 0; n_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(IDX_SEL_FIRST, 32'hff, 1'b0);
        rd(IDX_SEL_LAST, 32'hff, 1'b0);
        rd(IDX_HORIZONTAL_PIXEL_OFFSET_LO, 32'h47, 1'b0);
        rd(IDX_VERTICAL_LINE_OFFSET_LO, 32'h03, 1'b0);
        rd(IDX_OFFS_HI, 32'h03, 1'b0);
        rd(IDX_ROUTE, 32'h0, 1'b0);
        rd(IDX_STATUS, 32'h000f_5800, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        apb(1'b1, IDX_OFFS_HI, 32'hff);
        rd(IDX_OFFS_HI, 32'h97, 1'b0);
        apb(1'b1, IDX_OFFS_HI, 32'h03);
        // every code appears in both nibbles
        for (int n = 2; n <= 24; n++) begin
            sel_v[n] = {4'(n - 2), 4'(n + 7)};
            apb(1'b1, 8'(8'h3f + n), {24'h0, sel_v[n]});
        end
        rd(IDX_SEL_FIRST + 8'h5, {24'h0, sel_v[7]}, 1'b0);
        walk(1'b0, 9'h003, 1'b0, 27);
        walk(1'b1, 9'h003, 1'b0, 27);
        apb(1'b1, IDX_VERTICAL_LINE_OFFSET_LO, 32'h06);
        apb(1'b1, IDX_OFFS_HI, 32'h83);
        walk(1'b0, 9'h006, 1'b1, 28);
        walk(1'b1, 9'h006, 1'b1, 28);
        // each route choice against each single reference
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, IDX_ROUTE, {18'h0, 2'(s), 3'h0, 1'(s), 1'b0, 3'(7 - s), 1'b0, 3'(s)});
            for (int p = 0; p < 5; p++) begin
                @(posedge clk);
                rf <= vlts_ref_s'(5'h1 << p);
                @(posedge clk);
                #1;
                chk({28'h0, rt0, rt1, expansion_horiz_ref_pin, expansion_vert_ref_pin}, {28'h0, pick(3'(s), rf), pick(3'(7 - s), rf),
                    s[0] & rf.horizontal_reference, (s % 4 == 1) ? rf.field_flag_656 :
                    (s % 4 == 2) ? rf.vertical_pulse : 1'b0});
            end
        end
        results();
    end

    function automatic logic pick(input logic [2:0] v, input vlts_ref_s r);
        case (v)
            3'h1: return r.horizontal_reference;
            3'h2: return r.vertical_pulse;
            3'h3: return r.vertical_gate;
            3'h4: return r.field_identifier;
            default: return 1'b0;
        endcase
    endfunction

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire

// File: verif/vlts_line_src.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// sync and sample source model
// ----------------------------------------------------------------------
module vlts_line_src (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_go_line,
    input  wire logic        i_go_field,
    input  wire logic        i_f2,
    output logic             o_line_start,
    output logic             o_field_start,
    output logic             o_field2,
    output logic             o_pix_valid,
    output logic      [15:0] o_pix_data
);
    // one pulse per request, data changes every cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_line_start  <= 1'b0;
            o_field_start <= 1'b0;
            o_field2      <= 1'b0;
            o_pix_valid   <= 1'b0;
            o_pix_data    <= 16'h0;
        end else begin
            o_line_start  <= i_go_line;
            o_field_start <= i_go_field;
            o_field2      <= i_go_field ? i_f2 : o_field2;
            o_pix_valid   <= i_go_line | i_go_field;
            o_pix_data    <= o_pix_data + 16'h1d3b;
        end
    end
endmodule
`default_nettype wire

// File: verif/vlts_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// port checker for the line type selector
// ----------------------------------------------------------------------
module vlts_props
    import vlts_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_line_start,
    input wire logic        i_field_start,
    input wire vlts_ref_s   i_ref,
    input wire logic        i_pix_valid,
    input wire logic [15:0] i_pix_data,
    input wire vlts_pix_s   o_pix,
    input wire logic        o_set_active,
    input wire logic        o_realtime_out_0,
    input wire logic        o_realtime_out_1,
    input wire logic        o_expansion_horiz_ref_pin,
    input wire logic        o_expansion_vert_ref_pin
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // bus answer timing
    property p_ack; i_psel && !i_penable |=> o_pready; endproperty
    property p_ack_one; o_pready |=> !o_pready; endproperty
    property p_err; o_pslverr |-> o_pready; endproperty
    // pins only carry their allowed sources
    property p_xrh; o_expansion_horiz_ref_pin |-> $past(i_ref.horizontal_reference); endproperty
    property p_xrv;
        o_expansion_vert_ref_pin |-> $past(i_ref.field_flag_656 | i_ref.vertical_pulse);
    endproperty
    property p_rt0;
        o_realtime_out_0 |-> $past(i_ref.horizontal_reference | i_ref.vertical_pulse
            | i_ref.vertical_gate | i_ref.field_identifier);
    endproperty
    property p_rt1;
        o_realtime_out_1 |-> $past(i_ref.horizontal_reference | i_ref.vertical_pulse
            | i_ref.vertical_gate | i_ref.field_identifier);
    endproperty
    // samples pass with one cycle lag
    property p_pix_valid; o_pix.valid == $past(i_pix_valid); endproperty
    property p_pix_data; i_pix_valid |=> o_pix.data == $past(i_pix_data); endproperty
    // raw mark exclusive of the others, active mark held within a line
    property p_excl; !(o_pix.set_raw && (o_pix.set_vbi || o_set_active)); endproperty
    property p_hold; !i_line_start && !i_field_start |=> $stable(o_set_active); endproperty

    a_ack: assert property (p_ack) else $error("no ready after setup");
    a_ack_one: assert property (p_ack_one) else $error("ready too long");
    a_err: assert property (p_err) else $error("error without ready");
    a_xrh: assert property (p_xrh) else $error("bad horiz pin source");
    a_xrv: assert property (p_xrv) else $error("bad vert pin source");
    a_rt0: assert property (p_rt0) else $error("bad rt0 source");
    a_rt1: assert property (p_rt1) else $error("bad rt1 source");
    a_pix_valid: assert property (p_pix_valid) else $error("valid lag wrong");
    a_pix_data: assert property (p_pix_data) else $error("data lag wrong");
    a_excl: assert property (p_excl) else $error("marks overlap");
    a_hold: assert property (p_hold) else $error("mark moved mid line");

    c_vbi: cover property (o_pix.valid && o_pix.set_vbi);
    c_act: cover property (o_pix.valid && o_set_active);
    c_err: cover property (o_pslverr);
endmodule

bind vlts_top vlts_props chk_u (.i_mclk, .i_rst_n, .i_psel, .i_penable, .o_pready,
    .o_pslverr, .i_line_start, .i_field_start, .i_ref, .i_pix_valid, .i_pix_data, .o_pix,
    .o_set_active, .o_realtime_out_0, .o_realtime_out_1, .o_expansion_horiz_ref_pin,
    .o_expansion_vert_ref_pin);
`default_nettype wire
